// ==== rtl/dtd_pkg.sv ====
// constants, types and opcode timing tables for the data-transfer decoder
package dtd_pkg;

  // opcode bytes
  localparam logic [7:0] OP_SEG_LOAD      = 8'h8e;
  localparam logic [7:0] OP_SEG_STORE     = 8'h8c;
  localparam logic [7:0] OP_FAR_DATA_SEG  = 8'hc5;
  localparam logic [7:0] OP_FAR_EXTRA_SEG = 8'hc4;
  localparam logic [7:0] OP_TABLE_LOOKUP  = 8'hd7;
  localparam logic [7:0] OP_LOAD_EA       = 8'h8d;
  localparam logic [7:0] OP_FLAGS_TO_ACC  = 8'h9f;
  localparam logic [7:0] OP_ACC_TO_FLAGS  = 8'h9e;
  localparam logic [7:0] OP_MOV_TO_RM     = 8'h88;
  localparam logic [7:0] OP_MOV_FROM_RM   = 8'h8a;
  localparam logic [7:0] OP_W_MASK        = 8'hfe;

  // mod/reg/rm byte fields
  localparam int unsigned MOD_HI   = 7;
  localparam int unsigned MOD_LO   = 6;
  localparam int unsigned REG_HI   = 5;
  localparam int unsigned REG_LO   = 3;
  localparam int unsigned RM_HI    = 2;
  localparam int unsigned RM_LO    = 0;
  localparam int unsigned SEG_ZERO = 5;
  localparam int unsigned W_BIT    = 0;
  localparam logic [1:0]  MOD_REG  = 2'h3;

  // minimum clock counts: register form / wide bus / narrow bus
  localparam logic [7:0] CNT_REG_FORM     = 8'h02;
  localparam logic [7:0] CNT_SEG_LOAD_W   = 8'h09;
  localparam logic [7:0] CNT_SEG_LOAD_N   = 8'h0d;
  localparam logic [7:0] CNT_SEG_STORE_W  = 8'h0b;
  localparam logic [7:0] CNT_SEG_STORE_N  = 8'h0f;
  localparam logic [7:0] CNT_FAR_W        = 8'h12;
  localparam logic [7:0] CNT_FAR_N        = 8'h1a;
  localparam logic [7:0] CNT_TABLE_W      = 8'h0b;
  localparam logic [7:0] CNT_TABLE_N      = 8'h0f;
  localparam logic [7:0] CNT_LOAD_EA      = 8'h06;
  localparam logic [7:0] CNT_FLAGS_TO_ACC = 8'h02;
  localparam logic [7:0] CNT_ACC_TO_FLAGS = 8'h03;
  localparam logic [7:0] CNT_MOV_TO_MEM   = 8'h0c;
  localparam logic [7:0] CNT_MOV_FROM_MEM = 8'h09;
  localparam logic [7:0] CNT_WORD_EXTRA   = 8'h04;
  localparam logic [7:0] CNT_MISALIGN     = 8'h04;
  localparam logic [7:0] STEP_OPCODE      = 8'h01;
  localparam logic [7:0] STEP_MODRM       = 8'h02;

  // prefetch queue
  localparam logic [2:0] QDEPTH_WIDE   = 3'h6;
  localparam logic [2:0] QDEPTH_NARROW = 3'h4;
  localparam logic [3:0] PUSH_WIDE     = 4'h2;
  localparam logic [3:0] PUSH_NARROW   = 4'h1;

  typedef enum logic [3:0] {
    CLS_NONE,
    CLS_SEG_LOAD,
    CLS_SEG_STORE,
    CLS_LOAD_FAR_POINTER_DATA_SEG,
    CLS_LOAD_FAR_POINTER_EXTRA_SEG,
    CLS_TABLE_LOOKUP_BYTE,
    CLS_LOAD_EFFECTIVE_ADDRESS,
    CLS_FLAGS_TO_ACC_HIGH,
    CLS_ACC_HIGH_TO_FLAGS,
    CLS_MOV_TO_RM,
    CLS_MOV_FROM_RM
  } dtd_class_e;

  typedef enum logic [1:0] {
    ST_FETCH,
    ST_MODRM,
    ST_EXEC
  } dtd_state_e;

endpackage

// ==== rtl/dtd_queue_if.sv ====
// link between the prefetch queue and the decoder
`timescale 1ns/1ps
`default_nettype none
interface dtd_queue_if;
  logic [7:0] head_byte;
  logic       head_valid;
  logic [2:0] level;
  logic       pop;
  logic       flush;
  logic       narrow;

  modport queue (
    output head_byte,
    output head_valid,
    output level,
    input  pop,
    input  flush,
    input  narrow
  );

  modport consumer (
    input  head_byte,
    input  head_valid,
    input  level,
    output pop,
    output flush,
    output narrow
  );
endinterface
`default_nettype wire

// ==== rtl/dtd_prefetch_queue.sv ====
// instruction prefetch queue, six bytes deep, four usable on the narrow bus
`timescale 1ns/1ps
`default_nettype none
module dtd_prefetch_queue
  import dtd_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // bus interface unit fill side
  input  wire logic [15:0] fetch_data_i,
  input  wire logic        fetch_valid_i,
  output logic             fetch_ready_o,
  // decoder side
  dtd_queue_if.queue       q
);

  logic [7:0] mem_reg [QDEPTH_WIDE];
  logic [2:0] head_reg;
  logic [2:0] count_reg;

  function automatic logic [2:0] wrap(input logic [3:0] idx);
    wrap = (idx >= {1'b0, QDEPTH_WIDE}) ? 3'(idx - {1'b0, QDEPTH_WIDE}) : idx[2:0];
  endfunction

  wire logic [2:0] limit   = q.narrow ? QDEPTH_NARROW : QDEPTH_WIDE;
  wire logic [3:0] push_n  = q.narrow ? PUSH_NARROW : PUSH_WIDE;
  wire logic       pop_ok  = q.pop && (count_reg != 3'h0);
  wire logic [2:0] tail    = wrap({1'b0, head_reg} + {1'b0, count_reg});
  wire logic [2:0] tail_hi = wrap({1'b0, tail} + 4'h1);
  wire logic       push    = fetch_valid_i && fetch_ready_o;

  // a push needs room for the whole transfer; a flush refetches from the target
  assign fetch_ready_o = !q.flush && (({1'b0, count_reg} + push_n) <= {1'b0, limit});
  assign q.head_byte   = mem_reg[head_reg];
  assign q.head_valid  = (count_reg != 3'h0);
  assign q.level       = count_reg;

  wire logic [3:0] count_next = {1'b0, count_reg} + (push ? push_n : 4'h0)
                                - {3'h0, pop_ok};

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[tail] <= fetch_data_i[7:0];
    end
    if (push && !q.narrow) begin
      mem_reg[tail_hi] <= fetch_data_i[15:8];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      head_reg  <= 3'h0;
      count_reg <= 3'h0;
    end else if (q.flush) begin
      head_reg  <= 3'h0;
      count_reg <= 3'h0;
    end else begin
      head_reg  <= wrap({1'b0, head_reg} + {3'h0, pop_ok});
      count_reg <= count_next[2:0];
    end
  end

  chk_fill_within_limit: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (push && !q.flush) |=> (count_reg <= $past(limit)))
    else $error("prefetch queue filled beyond its depth");

  chk_wide_two_bytes: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (push && !q.narrow && !q.flush && !pop_ok)
      |=> (count_reg == 3'($past(count_reg) + 3'h2)))
    else $error("wide bus transfer did not add two bytes");

  chk_level_bound: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    q.level <= limit)
    else $error("prefetch queue level beyond the variant depth");

endmodule
`default_nettype wire

// ==== rtl/dtd_decode_timing.sv ====
// data-transfer opcode decoder and execution timing sequencer
// Operation
// - 8e decodes as segment load, 2/9, 2/13
// - 8c decodes as segment store, 2/11, 2/15
// - c5 far pointer to data segment
// - c4 far pointer to extra segment
// - d7 table lookup byte, 11 or 15
// - 8d load effective address, 6 clocks
// - 9f flags into accumulator high, 2
// - 9e accumulator high into flags, 3
// - narrow bus word moves (88/89, 8a/8b) to or from memory add four
// - memory ops may wait for bus handshake
// - wide variant has six byte queue
// - narrow variant has four byte queue
// - branch target fetch counted after flush; the decoder counts only from the next opcode byte
// - minimum only when queue holds bytes
// - misaligned wide-bus words take extra time
// - sixteen or eight bit bus unit fill
`timescale 1ns/1ps
`default_nettype none
module dtd_decode_timing
  import dtd_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // bus interface unit prefetch
  input  wire logic [15:0] fetch_data_i,
  input  wire logic        fetch_valid_i,
  output logic             fetch_ready_o,
  // variant strap pin
  input  wire logic        narrow_bus_i,
  // execution unit
  input  wire logic        flush_i,
  input  wire logic        mem_done_i,
  input  wire logic        ea_odd_i,
  output var dtd_class_e   op_class_o,
  output logic [1:0]       mod_o,
  output logic [2:0]       reg_o,
  output logic [2:0]       rm_o,
  output logic             word_o,
  output logic             mem_req_o,
  output logic             busy_o,
  output logic             stall_o,
  output logic             done_o,
  output logic             invalid_o,
  output logic [7:0]       cycles_o,
  output logic [7:0]       min_cycles_o
);

  dtd_queue_if q ();

  dtd_state_e state_reg;
  dtd_class_e cls_reg;
  logic [7:0] modrm_reg;
  logic       word_reg;
  logic       mem_reg;
  logic       narrow_at_reg;
  logic       mem_seen_reg;
  logic       stall_seen_reg;
  logic       late_reg;
  logic       invalid_reg;
  logic [7:0] rem_reg;
  logic [7:0] el_reg;
  logic [7:0] cycles_reg;
  logic [7:0] min_reg;
  logic       nb_meta_reg;
  logic       nb_sync_reg;

  function automatic dtd_class_e decode_class(input logic [7:0] op);
    if ((op & OP_W_MASK) == OP_MOV_TO_RM) begin
      decode_class = CLS_MOV_TO_RM;
    end else if ((op & OP_W_MASK) == OP_MOV_FROM_RM) begin
      decode_class = CLS_MOV_FROM_RM;
    end else begin
      case (op)
        OP_SEG_LOAD:      decode_class = CLS_SEG_LOAD;
        OP_SEG_STORE:     decode_class = CLS_SEG_STORE;
        OP_FAR_DATA_SEG:  decode_class = CLS_LOAD_FAR_POINTER_DATA_SEG;
        OP_FAR_EXTRA_SEG: decode_class = CLS_LOAD_FAR_POINTER_EXTRA_SEG;
        OP_TABLE_LOOKUP:  decode_class = CLS_TABLE_LOOKUP_BYTE;
        OP_LOAD_EA:       decode_class = CLS_LOAD_EFFECTIVE_ADDRESS;
        OP_FLAGS_TO_ACC:  decode_class = CLS_FLAGS_TO_ACC_HIGH;
        OP_ACC_TO_FLAGS:  decode_class = CLS_ACC_HIGH_TO_FLAGS;
        default:          decode_class = CLS_NONE;
      endcase
    end
  endfunction

  function automatic logic is_word(input dtd_class_e cls, input logic [7:0] op);
    case (cls)
      CLS_MOV_TO_RM, CLS_MOV_FROM_RM:                 is_word = op[W_BIT];
      CLS_TABLE_LOOKUP_BYTE, CLS_FLAGS_TO_ACC_HIGH,
      CLS_ACC_HIGH_TO_FLAGS:                          is_word = 1'b0;
      default:                                        is_word = 1'b1;
    endcase
  endfunction

  function automatic logic [7:0] cost(input dtd_class_e cls, input logic mem,
                                      input logic narrow, input logic word,
                                      input logic odd);
    logic [7:0] base;
    logic       starred;
    base    = CNT_REG_FORM;
    starred = 1'b0;
    case (cls)
      CLS_SEG_LOAD:  base = mem ? (narrow ? CNT_SEG_LOAD_N : CNT_SEG_LOAD_W) : CNT_REG_FORM;
      CLS_SEG_STORE: base = mem ? (narrow ? CNT_SEG_STORE_N : CNT_SEG_STORE_W) : CNT_REG_FORM;
      CLS_LOAD_FAR_POINTER_DATA_SEG,
      CLS_LOAD_FAR_POINTER_EXTRA_SEG: base = narrow ? CNT_FAR_N : CNT_FAR_W;
      CLS_TABLE_LOOKUP_BYTE:      base = narrow ? CNT_TABLE_N : CNT_TABLE_W;
      CLS_LOAD_EFFECTIVE_ADDRESS: base = CNT_LOAD_EA;
      CLS_FLAGS_TO_ACC_HIGH:      base = CNT_FLAGS_TO_ACC;
      CLS_ACC_HIGH_TO_FLAGS:      base = CNT_ACC_TO_FLAGS;
      CLS_MOV_TO_RM: begin
        base    = mem ? CNT_MOV_TO_MEM : CNT_REG_FORM;
        starred = 1'b1;
      end
      CLS_MOV_FROM_RM: begin
        base    = mem ? CNT_MOV_FROM_MEM : CNT_REG_FORM;
        starred = 1'b1;
      end
      default: base = CNT_REG_FORM;
    endcase
    // narrow-bus counts of starred entries are quoted for bytes
    if (starred && narrow && word && mem) begin
      base = 8'(base + CNT_WORD_EXTRA);
    end
    // an odd word needs two bus cycles on the wide bus
    if (!narrow && word && mem && odd) begin
      base = 8'(base + CNT_MISALIGN);
    end
    cost = base;
  endfunction

  // the strap is a pin, so it is synchronised before use
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nb_meta_reg <= 1'b0;
      nb_sync_reg <= 1'b0;
    end else begin
      nb_meta_reg <= narrow_bus_i;
      nb_sync_reg <= nb_meta_reg;
    end
  end

  dtd_prefetch_queue u_queue (
    .clk_i         (clk_i),
    .rst_b_i       (rst_b_i),
    .fetch_data_i  (fetch_data_i),
    .fetch_valid_i (fetch_valid_i),
    .fetch_ready_o (fetch_ready_o),
    .q             (q)
  );

  // decode of the byte at the queue head
  wire dtd_class_e head_cls    = decode_class(q.head_byte);
  wire logic       head_modrm  = !(head_cls == CLS_TABLE_LOOKUP_BYTE
                                   || head_cls == CLS_FLAGS_TO_ACC_HIGH
                                   || head_cls == CLS_ACC_HIGH_TO_FLAGS);
  wire logic       take_op     = (state_reg == ST_FETCH) && q.head_valid && !flush_i;
  wire logic       take_modrm  = (state_reg == ST_MODRM) && q.head_valid && !flush_i;
  wire logic [1:0] head_mod    = q.head_byte[MOD_HI:MOD_LO];
  wire logic       head_mem    = (head_mod != MOD_REG);
  wire logic       far_cls     = (cls_reg == CLS_LOAD_FAR_POINTER_DATA_SEG)
                                 || (cls_reg == CLS_LOAD_FAR_POINTER_EXTRA_SEG);
  wire logic       seg_cls     = (cls_reg == CLS_SEG_LOAD) || (cls_reg == CLS_SEG_STORE);
  wire logic       bad_modrm   = (far_cls && !head_mem)
                                 || (seg_cls && q.head_byte[SEG_ZERO]);
  // effective-address load computes an address but makes no bus access
  wire logic       modrm_mem   = head_mem && (cls_reg != CLS_LOAD_EFFECTIVE_ADDRESS);
  wire logic [7:0] op_cost     = cost(head_cls, 1'b1, nb_sync_reg, 1'b0, 1'b0);
  wire logic [7:0] modrm_cost  = cost(cls_reg, head_mem, nb_sync_reg, word_reg, ea_odd_i);
  wire logic       exec_end    = (state_reg == ST_EXEC) && (rem_reg == 8'h00);
  wire logic       mem_ok      = !mem_reg || mem_seen_reg || mem_done_i;

  assign q.pop    = take_op || take_modrm;
  assign q.flush  = flush_i;
  assign q.narrow = nb_sync_reg;

  assign done_o       = exec_end && mem_ok;
  assign mem_req_o    = (state_reg == ST_EXEC) && mem_reg && !mem_seen_reg;
  assign busy_o       = (state_reg != ST_FETCH);
  assign stall_o      = !q.head_valid && (state_reg != ST_EXEC);
  assign op_class_o   = cls_reg;
  assign mod_o        = modrm_reg[MOD_HI:MOD_LO];
  assign reg_o        = modrm_reg[REG_HI:REG_LO];
  assign rm_o         = modrm_reg[RM_HI:RM_LO];
  assign word_o       = word_reg;
  assign invalid_o    = invalid_reg;
  assign cycles_o     = cycles_reg;
  assign min_cycles_o = min_reg;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_FETCH;
      rem_reg   <= 8'h00;
    end else begin
      case (state_reg)
        ST_FETCH: begin
          if (take_op && head_cls != CLS_NONE && head_modrm) begin
            state_reg <= ST_MODRM;
          end else if (take_op && head_cls != CLS_NONE) begin
            state_reg <= ST_EXEC;
            rem_reg   <= 8'(op_cost - STEP_OPCODE);
          end
        end
        ST_MODRM: begin
          if (flush_i || (take_modrm && bad_modrm)) begin
            state_reg <= ST_FETCH;
          end else if (take_modrm) begin
            state_reg <= ST_EXEC;
            rem_reg   <= 8'(modrm_cost - STEP_MODRM);
          end
        end
        ST_EXEC: begin
          if (rem_reg != 8'h00) begin
            rem_reg <= 8'(rem_reg - STEP_OPCODE);
          end else if (mem_ok) begin
            state_reg <= ST_FETCH;
          end
        end
        default: state_reg <= ST_FETCH;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cls_reg       <= CLS_NONE;
      modrm_reg     <= 8'h00;
      word_reg      <= 1'b0;
      mem_reg       <= 1'b0;
      narrow_at_reg <= 1'b0;
      min_reg       <= 8'h00;
    end else if (take_op) begin
      cls_reg       <= head_cls;
      modrm_reg     <= 8'h00;
      word_reg      <= is_word(head_cls, q.head_byte);
      mem_reg       <= (head_cls == CLS_TABLE_LOOKUP_BYTE);
      narrow_at_reg <= nb_sync_reg;
      min_reg       <= op_cost;
    end else if (take_modrm && !bad_modrm) begin
      modrm_reg     <= q.head_byte;
      mem_reg       <= modrm_mem;
      narrow_at_reg <= nb_sync_reg;
      min_reg       <= modrm_cost;
    end
  end

  // handshake completion may land before the count runs out; keep it
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mem_seen_reg <= 1'b0;
    end else if (state_reg == ST_EXEC && mem_done_i) begin
      mem_seen_reg <= 1'b1;
    end else if (state_reg != ST_EXEC) begin
      mem_seen_reg <= 1'b0;
    end
  end

  // elapsed clocks since the opcode byte was taken
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      el_reg         <= 8'h00;
      cycles_reg     <= 8'h00;
      stall_seen_reg <= 1'b0;
      late_reg       <= 1'b0;
      invalid_reg    <= 1'b0;
    end else begin
      invalid_reg <= (take_op && head_cls == CLS_NONE) || (take_modrm && bad_modrm);
      if (take_op) begin
        el_reg         <= STEP_OPCODE;
        stall_seen_reg <= 1'b0;
        late_reg       <= 1'b0;
      end else if (busy_o) begin
        el_reg <= 8'(el_reg + STEP_OPCODE);
      end
      if (state_reg == ST_MODRM && !q.head_valid) begin
        stall_seen_reg <= 1'b1;
      end
      if (exec_end && !mem_ok) begin
        late_reg <= 1'b1;
      end
      if (done_o) begin
        cycles_reg <= el_reg;
      end
    end
  end

  sequence seq_done_of(dtd_class_e c);
    done_o && (cls_reg == c);
  endsequence

  sequence seq_waiting_bus;
    exec_end && mem_reg && !mem_seen_reg && !mem_done_i;
  endsequence

  chk_min_exact_clean: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (done_o && !stall_seen_reg && !late_reg) |-> (el_reg == min_reg))
    else $error("clean instruction did not finish at its minimum count");

  chk_never_below_min: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    done_o |-> (el_reg >= min_reg))
    else $error("instruction finished below its minimum count");

  chk_seg_load_time: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    seq_done_of(CLS_SEG_LOAD) |-> (min_reg == (!mem_reg ? CNT_REG_FORM
      : (narrow_at_reg ? CNT_SEG_LOAD_N : CNT_SEG_LOAD_W))))
    else $error("segment load count wrong");

  chk_seg_store_time: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    seq_done_of(CLS_SEG_STORE) |-> (min_reg == (!mem_reg ? CNT_REG_FORM
      : (narrow_at_reg ? CNT_SEG_STORE_N : CNT_SEG_STORE_W))))
    else $error("segment store count wrong");

  chk_far_reg_refused: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (take_modrm && far_cls && !head_mem) |=> (invalid_o && state_reg == ST_FETCH))
    else $error("far pointer load with register operand was not refused");

  chk_far_time: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (done_o && far_cls) |-> (min_reg == (narrow_at_reg ? CNT_FAR_N : CNT_FAR_W)))
    else $error("far pointer load count wrong");

  chk_table_time: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    seq_done_of(CLS_TABLE_LOOKUP_BYTE)
      |-> (mem_reg && min_reg == (narrow_at_reg ? CNT_TABLE_N : CNT_TABLE_W)))
    else $error("table lookup count wrong");

  chk_ea_time: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    seq_done_of(CLS_LOAD_EFFECTIVE_ADDRESS) |-> (min_reg == CNT_LOAD_EA && !mem_reg))
    else $error("effective address load count wrong");

  chk_flag_moves: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (done_o && !late_reg && !stall_seen_reg
      && (cls_reg == CLS_FLAGS_TO_ACC_HIGH || cls_reg == CLS_ACC_HIGH_TO_FLAGS))
      |-> (el_reg == ((cls_reg == CLS_FLAGS_TO_ACC_HIGH) ? CNT_FLAGS_TO_ACC
                                                       : CNT_ACC_TO_FLAGS)))
    else $error("flag transfer count wrong");

  chk_word_extra: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    seq_done_of(CLS_MOV_FROM_RM) and (mem_reg && narrow_at_reg && word_reg)
      |-> (min_reg == 8'(CNT_MOV_FROM_MEM + CNT_WORD_EXTRA)))
    else $error("narrow bus word transfer lacks its extra clocks");

  chk_mem_wait: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    seq_waiting_bus |-> (!done_o && mem_req_o) ##1 (state_reg == ST_EXEC))
    else $error("memory instruction finished before the bus handshake");

endmodule
`default_nettype wire

// ==== dv/dtd_bus_model.sv ====
// bus unit model that feeds prefetch words into the decoder
`timescale 1ns/1ps
`default_nettype none
module dtd_bus_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // strap and fill port
  input  wire logic        narrow_i,
  input  wire logic        fetch_ready_i,
  output logic [15:0]      fetch_data_o,
  output logic             fetch_valid_o
);
  logic [7:0]  q[$];
  int unsigned n;

  function automatic void push(input logic [7:0] b);
    q.push_back(b);
  endfunction

  // an offer stays put until taken; idle lines toggle so stale bytes never look valid
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fetch_valid_o <= 1'b0;
      fetch_data_o  <= 16'h0000;
    end else begin
      n = narrow_i ? 1 : 2;
      if (fetch_valid_o && fetch_ready_i) repeat (n) void'(q.pop_front());
      if (q.size() >= n) begin
        fetch_valid_o <= 1'b1;
        fetch_data_o  <= {(narrow_i ? ~q[0] : q[1]), q[0]};
      end else begin
        fetch_valid_o <= 1'b0;
        fetch_data_o  <= ~fetch_data_o;
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/data_transfer_decode_timing_bench.sv ====
// self-checking bench for the data-transfer decoder
`timescale 1ns/1ps
`default_nettype none
module data_transfer_decode_timing_bench;
  import dtd_pkg::*;
  logic       clk_i = 1'b0;
  logic       rst_b_i = 1'b0;
  logic       narrow_bus_i = 1'b0;
  logic       flush_i = 1'b0;
  logic       mem_done_i = 1'b1;
  logic       ea_odd_i = 1'b0;
  logic [1:0] mod_o;
  logic [2:0] reg_o;
  logic [2:0] rm_o;
  logic       word_o;
  logic       mem_req_o;
  logic       busy_o;
  logic       stall_o;
  wire [15:0] fetch_data;
  wire        fetch_valid;
  wire        fetch_ready;
  dtd_class_e op_class_o;
  logic [7:0] cycles_o;
  logic [7:0] min_cycles_o;
  logic       done_o;
  logic       invalid_o;
  int         err_total = 0;
  int         num_checks = 0;

  always #4 clk_i = ~clk_i;

  dtd_bus_model u_dtd_bus_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .narrow_i(narrow_bus_i),
    .fetch_ready_i(fetch_ready), .fetch_data_o(fetch_data), .fetch_valid_o(fetch_valid));

  dtd_decode_timing u_dtd_decode_timing (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .fetch_data_i(fetch_data), .fetch_valid_i(fetch_valid), .fetch_ready_o(fetch_ready),
    .narrow_bus_i(narrow_bus_i), .flush_i(flush_i), .mem_done_i(mem_done_i),
    .ea_odd_i(ea_odd_i), .op_class_o(op_class_o), .mod_o(mod_o), .reg_o(reg_o), .rm_o(rm_o),
    .word_o(word_o), .mem_req_o(mem_req_o), .busy_o(busy_o), .stall_o(stall_o),
    .done_o(done_o), .invalid_o(invalid_o),
    .cycles_o(cycles_o), .min_cycles_o(min_cycles_o));

  task automatic print_verdict;
    if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] act, input logic [7:0] exp);
    num_checks++;
    if (act !== exp) begin
      err_total++;
      $display("[ERR] t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask

  task automatic cmp_cls(input dtd_class_e act, input dtd_class_e exp);
    num_checks++;
    if (act !== exp) begin
      err_total++;
      $display("[ERR] t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask

  // strap changes only under reset, since the decoder resyncs it
  task automatic reset_dut(input logic nar);
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    narrow_bus_i <= nar;
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  // b1 may already be the next opcode; nb bytes go to the bus model
  task automatic op(input logic [7:0] b0, input logic [7:0] b1, input int nb,
                    input dtd_class_e cls, input logic [7:0] cyc);
    int k;
    k = 0;
    if (nb > 0) u_dtd_bus_model.push(b0);
    if (nb > 1) u_dtd_bus_model.push(b1);
    while (done_o !== 1'b1) begin
      @(posedge clk_i);
      #1;
      if (++k > 200) begin
        err_total++;
        print_verdict();
      end
    end
    cmp_cls(op_class_o, cls);
    cmp8(min_cycles_o, cyc);
    @(posedge clk_i);
    #1;
    cmp8(cycles_o, cyc);
  endtask

  // two bytes that must be refused; the decoder has to end up idle
  task automatic refused(input logic [7:0] b0, input logic [7:0] b1);
    logic hit;
    hit = 1'b0;
    u_dtd_bus_model.push(b0);
    u_dtd_bus_model.push(b1);
    repeat (8) begin
      @(posedge clk_i);
      #1;
      hit |= (invalid_o === 1'b1);
    end
    cmp8({6'h00, hit, busy_o}, 8'h02);
  endtask

  // opcode without its mod/reg/rm byte, then a flush abandons it
  task automatic flush_modrm;
    u_dtd_bus_model.push(8'h8e);
    repeat (6) begin
      @(posedge clk_i);
      #1;
    end
    cmp8({6'h00, stall_o, busy_o}, 8'h03);
    @(posedge clk_i);
    flush_i <= 1'b1;
    #1;
    cmp8({7'h00, fetch_ready}, 8'h00);
    @(posedge clk_i);
    flush_i <= 1'b0;
    #1;
    cmp8({6'h00, stall_o, busy_o}, 8'h02);
  endtask

  // handshake held four clocks past the count; done must wait for it
  task automatic mem_hold;
    logic early;
    early = 1'b0;
    @(posedge clk_i);
    mem_done_i <= 1'b0;
    #1;
    u_dtd_bus_model.push(8'hd7);
    repeat (20) begin
      @(posedge clk_i);
      #1;
      early |= (done_o === 1'b1);
    end
    cmp8({6'h00, early, mem_req_o}, 8'h01);
    @(posedge clk_i);
    mem_done_i <= 1'b1;
    #1;
    cmp8({7'h00, done_o}, 8'h01);
    cmp8(min_cycles_o, CNT_TABLE_N);
    @(posedge clk_i);
    #1;
    cmp8(cycles_o, 8'(CNT_TABLE_N + 8'h04));
  endtask

  initial begin
    reset_dut(1'b0);
    op(8'h9f, 8'h9e, 2, CLS_FLAGS_TO_ACC_HIGH, 8'h02);
    op(8'h00, 8'h00, 0, CLS_ACC_HIGH_TO_FLAGS, 8'h03);
    op(8'h8e, 8'h06, 2, CLS_SEG_LOAD, 8'h09);
    op(8'h8e, 8'hc0, 2, CLS_SEG_LOAD, 8'h02);
    op(8'h8c, 8'h06, 2, CLS_SEG_STORE, 8'h0b);
    op(8'hc5, 8'h06, 2, CLS_LOAD_FAR_POINTER_DATA_SEG, 8'h12);
    op(8'hc4, 8'h06, 2, CLS_LOAD_FAR_POINTER_EXTRA_SEG, 8'h12);
    op(8'h8d, 8'h06, 2, CLS_LOAD_EFFECTIVE_ADDRESS, 8'h06);
    op(8'hd7, 8'h9f, 2, CLS_TABLE_LOOKUP_BYTE, 8'h0b);
    op(8'h00, 8'h00, 0, CLS_FLAGS_TO_ACC_HIGH, 8'h02);
    refused(8'hc5, 8'hc0);
    refused(8'hc4, 8'hc0);
    refused(8'h8e, 8'h26);
    op(8'h88, 8'h06, 2, CLS_MOV_TO_RM, 8'h0c);
    @(posedge clk_i);
    ea_odd_i <= 1'b1;
    #1;
    op(8'h8b, 8'h07, 2, CLS_MOV_FROM_RM, 8'h0d);
    cmp8({7'h00, word_o}, 8'h01);
    @(posedge clk_i);
    ea_odd_i <= 1'b0;
    reset_dut(1'b1);
    flush_modrm();
    mem_hold();
    op(8'h8e, 8'h06, 2, CLS_SEG_LOAD, 8'h0d);
    op(8'h8c, 8'h06, 2, CLS_SEG_STORE, 8'h0f);
    op(8'hc5, 8'h06, 2, CLS_LOAD_FAR_POINTER_DATA_SEG, 8'h1a);
    op(8'hc4, 8'h06, 2, CLS_LOAD_FAR_POINTER_EXTRA_SEG, 8'h1a);
    op(8'hd7, 8'h00, 1, CLS_TABLE_LOOKUP_BYTE, 8'h0f);
    op(8'h8b, 8'h06, 2, CLS_MOV_FROM_RM, 8'h0d);
    op(8'h89, 8'h06, 2, CLS_MOV_TO_RM, 8'h10);
    op(8'h8a, 8'h06, 2, CLS_MOV_FROM_RM, 8'h09);
    cmp8({7'h00, word_o}, 8'h00);
    op(8'h8d, 8'h06, 2, CLS_LOAD_EFFECTIVE_ADDRESS, 8'h06);
    cmp8({mod_o, reg_o, rm_o}, 8'h06);
    op(8'h9e, 8'h00, 1, CLS_ACC_HIGH_TO_FLAGS, 8'h03);
    print_verdict();
  end
endmodule
`default_nettype wire
